// file: desc_attr_pkg.sv
// Package with register map, field layout and reset values for the descriptor attribute registers.
package desc_attr_pkg;
	// Byte addresses of the attribute registers.
	localparam logic [7:0] STRING_LENGTH_SET_A_ADDR = 8'hA8;
	localparam logic [7:0] STRING_LENGTH_SET_B_ADDR = 8'hAC;
	localparam logic [7:0] EMULATED_CONFIG_FLAGS_ADDR = 8'hB0;
	// Extra control and status word gathering the loose bits.
	localparam logic [7:0] EMULATION_STATUS_ADDR = 8'hB4;
	// Field positions in string_length_set_a.
	localparam int CFG_LSB = 24;
	localparam int SER_LSB = 16;
	localparam int PROD_LSB = 8;
	localparam int MAKER_LSB = 0;
	localparam int LEN_W = 8;
	// Field positions in emulated_config_flags.
	localparam int REMOTE_WAKE_BIT = 17;
	localparam int POWER_METHOD_BIT = 16;
	localparam int GPIO_FLAGS_LSB = 0;
	localparam int GPIO_FLAGS_W = 8;
	// Field positions in the emulation status word.
	localparam int EMU_ENABLE_BIT = 0;
	localparam int EEPROM_SEEN_BIT = 1;
	localparam int EMU_ACTIVE_BIT = 2;
	// Reset values.
	localparam logic [7:0] LEN_RESET = 8'h00;
	localparam logic [7:0] GPIO_FLAGS_RESET = 8'h00;
	localparam logic [31:0] ZERO_WORD = 32'h00000000;
	// Number of address bits decoded on the bus.
	localparam int ADDR_W = 8;
endpackage

// file: strap_capture.sv
// Strap synchroniser that gives one load pulse each time reset is released, so the straps can be latched then.
`timescale 1ns/10ps
`default_nettype none
module strap_capture #(
	parameter int WIDTH = 2
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic [WIDTH-1:0] strap_i,
	output logic [WIDTH-1:0] sync_o,
	output logic load_o
);
	// Two-stage synchroniser; the first stage feeds only the second.
	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] meta_nxt;
	logic [WIDTH-1:0] sync_r;
	logic [WIDTH-1:0] sync_nxt;
	// Counts the edges after release so the straps are taken once synchronised values settle.
	logic [1:0] settle_r;
	logic [1:0] settle_nxt;
	logic load_r;
	logic load_nxt;

	// Elaboration check: a capture with no strap makes no sense.
	if (WIDTH < 1) begin : g_width_check
		$error("strap_capture needs at least one strap.");
	end

	// Next values: the synchroniser runs always, the settle counter restarts with reset.
	always_comb begin
		meta_nxt = strap_i;
		sync_nxt = meta_r;
		settle_nxt = settle_r;
		load_nxt = 1'b0;
		if (srst_i) begin
			settle_nxt = 2'b00;
		end else if (settle_r != 2'b11) begin
			settle_nxt = settle_r + 2'b01;
			// Load on the third edge after release, when sync_r holds a fresh sample.
			load_nxt = (settle_r == 2'b01);
		end
	end

	// Registers only; the synchroniser is not reset so it tracks the pins at all times.
	always_ff @(posedge clk_i) begin
		meta_r <= meta_nxt;
		sync_r <= sync_nxt;
		settle_r <= settle_nxt;
		load_r <= load_nxt;
	end

	assign sync_o = sync_r;
	assign load_o = load_r;
endmodule
`default_nettype wire

// file: descriptor_ram_attribute_regs.sv
// APB slave holding the string descriptor lengths and emulated configuration flags.
//
// Overview of operation
// - Contents act only without EEPROM and with emulation enabled.
// - Protected resets leave programmed contents unchanged.
// - Set A holds four byte lengths.
// - Set B holds interface length, rest reserved.
// - Flags: remote wake, power method, GPIO flags.
// - Remote wake and power method bits reset from sampled strap levels; GPIO flags reset to zero.
//
// Implementation choice: register access over APB.
`timescale 1ns/10ps
`default_nettype none
module descriptor_ram_attribute_regs (
	input wire logic REF_CLK_I,
	input wire logic SRST_I,
	// Reset that the reset-protection mechanism shields; it leaves the registers alone.
	input wire logic PROTECTED_RST_I,
	// APB slave port.
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [31:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	input wire logic [3:0] PSTRB_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	// Pins and status from the rest of the device.
	input wire logic REMOTE_WAKE_STRAP_I,
	input wire logic POWER_METHOD_STRAP_I,
	input wire logic EEPROM_PRESENT_I,
	// Values toward the descriptor engine.
	output logic EMULATION_ACTIVE_O,
	output logic [7:0] CONFIGURATION_STRING_LENGTH_O,
	output logic [7:0] SERIAL_STRING_LENGTH_O,
	output logic [7:0] PRODUCT_STRING_LENGTH_O,
	output logic [7:0] MAKER_STRING_LENGTH_O,
	output logic [7:0] INTERFACE_STRING_LENGTH_O,
	output logic REMOTE_WAKE_SUPPORT_O,
	output logic POWER_SOURCE_METHOD_O,
	output logic [7:0] GPIO_WAKE_EVENT_FLAGS_O
);
	// Stored fields. None of them looks at the protected reset, so a reset that the protection
	// shields passes them by; the plain synchronous reset clears them, except the two strap bits, which reload from the straps.
	// The four lengths of set A share one word because software always sets them together.
	logic [31:0] set_a_r;
	logic [31:0] set_a_nxt;
	logic [7:0] interface_len_r;
	logic [7:0] interface_len_nxt;
	logic remote_wake_r;
	logic remote_wake_nxt;
	logic power_method_r;
	logic power_method_nxt;
	logic [7:0] gpio_flags_r;
	logic [7:0] gpio_flags_nxt;
	logic descriptor_emulation_enable_r;
	logic descriptor_emulation_enable_nxt;
	// Bus answer registers. They hold the answer of the last access one cycle late; the bus
	// itself is served from the combinational image, and these copies are kept so that a wait
	// state can be added later without touching the decode.
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic slverr_r;
	logic slverr_nxt;
	// EEPROM presence comes from outside this clock domain and passes two flops.
	// The first flop may go metastable, so only the second one is read by any logic.
	// Emulation therefore reacts two to three cycles after the pin changes.
	logic eeprom_meta_r;
	logic eeprom_sync_r;
	logic active_r;
	logic active_nxt;
	// Strap capture outputs.
	logic [1:0] strap_sync;
	logic strap_load;

	// Access phase of an APB transfer; the slave answers with no wait states.
	// A write takes effect at the rising edge that ends the access phase, and read data is
	// presented during that same phase, so the master sees it where it samples ready.
	logic access;
	logic wr_en;
	logic rd_en;
	assign access = PSEL_I && PENABLE_I;
	assign wr_en = access && PWRITE_I;
	assign rd_en = access && !PWRITE_I;

	// True when the address hits a mapped word; the upper address bits must be zero too.
	// Checking the upper bits keeps aliases of the registers out of the map, so a stray
	// pointer above the decoded range answers with an error instead of corrupting a length.
	function automatic logic hit(input logic [31:0] a,
			input logic [desc_attr_pkg::ADDR_W-1:0] off);
		logic upper_clear;
		logic lower_match;
		upper_clear = (a[31:desc_attr_pkg::ADDR_W] == '0);
		lower_match = (a[desc_attr_pkg::ADDR_W-1:0] == off);
		return upper_clear && lower_match;
	endfunction

	// One length byte of set A, picked out at the given field position.
	function automatic logic [desc_attr_pkg::LEN_W-1:0] len_field(input logic [31:0] w,
			input int lsb);
		return w[lsb +: desc_attr_pkg::LEN_W];
	endfunction

	// Merge write data into a word under the byte strobes.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
			input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return res;
	endfunction

	logic hit_a;
	logic hit_b;
	logic hit_f;
	logic hit_s;
	logic mapped;
	assign hit_a = hit(PADDR_I, desc_attr_pkg::STRING_LENGTH_SET_A_ADDR);
	assign hit_b = hit(PADDR_I, desc_attr_pkg::STRING_LENGTH_SET_B_ADDR);
	assign hit_f = hit(PADDR_I, desc_attr_pkg::EMULATED_CONFIG_FLAGS_ADDR);
	assign hit_s = hit(PADDR_I, desc_attr_pkg::EMULATION_STATUS_ADDR);
	assign mapped = hit_a || hit_b || hit_f || hit_s;

	// Straps are synchronised and taken once after each release of SRST_I.
	// A strap that moves later than that is not followed; the pins are meant to be fixed
	// by board wiring, and following them would overwrite what software has written.
	strap_capture #(
		.WIDTH(2)
	) u_strap (
		.clk_i(REF_CLK_I),
		.srst_i(SRST_I),
		.strap_i({REMOTE_WAKE_STRAP_I, POWER_METHOD_STRAP_I}),
		.sync_o(strap_sync),
		.load_o(strap_load)
	);

	// Images of the registers as read back; reserved bits are zero.
	// The same images feed the read path and the byte merge of writes, so reserved bits can
	// never pick up write data: the merge result is sliced back to the defined fields only.
	logic [31:0] word_b;
	logic [31:0] word_f;
	logic [31:0] word_s;
	always_comb begin
		word_b = desc_attr_pkg::ZERO_WORD;
		word_b[desc_attr_pkg::LEN_W-1:0] = interface_len_r;
		word_f = desc_attr_pkg::ZERO_WORD;
		word_f[desc_attr_pkg::REMOTE_WAKE_BIT] = remote_wake_r;
		word_f[desc_attr_pkg::POWER_METHOD_BIT] = power_method_r;
		word_f[desc_attr_pkg::GPIO_FLAGS_LSB +: desc_attr_pkg::GPIO_FLAGS_W] = gpio_flags_r;
		word_s = desc_attr_pkg::ZERO_WORD;
		word_s[desc_attr_pkg::EMU_ENABLE_BIT] = descriptor_emulation_enable_r;
		word_s[desc_attr_pkg::EEPROM_SEEN_BIT] = eeprom_sync_r;
		word_s[desc_attr_pkg::EMU_ACTIVE_BIT] = active_r;
	end

	// Next values of the stored fields and the bus answer.
	// The strap load and a software write to the flag word may fall in one cycle; the write
	// is applied after the load and so wins, since software's value is the newer one.
	// Unmapped accesses change nothing; only the error answer marks them.
	always_comb begin
		logic [31:0] mb;
		logic [31:0] mf;
		logic [31:0] ms;
		mb = merge(word_b, PWDATA_I, PSTRB_I);
		mf = merge(word_f, PWDATA_I, PSTRB_I);
		ms = merge(word_s, PWDATA_I, PSTRB_I);
		set_a_nxt = set_a_r;
		interface_len_nxt = interface_len_r;
		remote_wake_nxt = remote_wake_r;
		power_method_nxt = power_method_r;
		gpio_flags_nxt = gpio_flags_r;
		descriptor_emulation_enable_nxt = descriptor_emulation_enable_r;
		rdata_nxt = desc_attr_pkg::ZERO_WORD;
		slverr_nxt = 1'b0;
		// The protected reset is deliberately not looked at here, so contents survive it.
		if (SRST_I) begin
			set_a_nxt = {4{desc_attr_pkg::LEN_RESET}};
			interface_len_nxt = desc_attr_pkg::LEN_RESET;
			gpio_flags_nxt = desc_attr_pkg::GPIO_FLAGS_RESET;
			descriptor_emulation_enable_nxt = 1'b0;
		end else begin
			// Strap levels become the reset values once they are synchronised.
			if (strap_load) begin
				remote_wake_nxt = strap_sync[1];
				power_method_nxt = strap_sync[0];
			end
			if (wr_en) begin
				// Byte-wise write; only defined bits are kept.
				if (hit_a) begin
					set_a_nxt = merge(set_a_r, PWDATA_I, PSTRB_I);
				end
				if (hit_b) begin
					interface_len_nxt = mb[desc_attr_pkg::LEN_W-1:0];
				end
				if (hit_f) begin
					// A write in the strap load cycle wins: software's value is newer.
					remote_wake_nxt = mf[desc_attr_pkg::REMOTE_WAKE_BIT];
					power_method_nxt = mf[desc_attr_pkg::POWER_METHOD_BIT];
					gpio_flags_nxt =
						mf[desc_attr_pkg::GPIO_FLAGS_LSB +: desc_attr_pkg::GPIO_FLAGS_W];
				end
				if (hit_s) begin
					// Only the enable bit is writable; status bits ignore writes.
					descriptor_emulation_enable_nxt = ms[desc_attr_pkg::EMU_ENABLE_BIT];
				end
			end
			// Unmapped addresses answer with an error and zero data.
			if (access && !mapped) begin
				slverr_nxt = 1'b1;
			end
			if (rd_en) begin
				unique case (1'b1)
					hit_a: rdata_nxt = set_a_r;
					hit_b: rdata_nxt = word_b;
					hit_f: rdata_nxt = word_f;
					hit_s: rdata_nxt = word_s;
					default: rdata_nxt = desc_attr_pkg::ZERO_WORD;
				endcase
			end
		end
		// Emulation is in force only with no EEPROM and the enable set.
		// An EEPROM that appears while emulation runs wins once it passes the two synchroniser flops, because its contents take
		// precedence over anything that software has staged here.
		active_nxt = descriptor_emulation_enable_r && !eeprom_sync_r;
		// Reset drops emulation until software enables it again.
		if (SRST_I) begin
			active_nxt = 1'b0;
		end
	end

	// Registers. The attribute fields take no action on PROTECTED_RST_I, which is how they
	// keep their programmed contents across protected resets.
	// The synchroniser flops carry no reset either: they only ever hold a copy of the pin.
	// Every flop here runs on every edge; reset is folded into the next-value logic above.
	always_ff @(posedge REF_CLK_I) begin
		set_a_r <= set_a_nxt;
		interface_len_r <= interface_len_nxt;
		remote_wake_r <= remote_wake_nxt;
		power_method_r <= power_method_nxt;
		gpio_flags_r <= gpio_flags_nxt;
		descriptor_emulation_enable_r <= descriptor_emulation_enable_nxt;
		eeprom_meta_r <= EEPROM_PRESENT_I;
		eeprom_sync_r <= eeprom_meta_r;
		active_r <= active_nxt;
	end

	// Read data and error are registered at the access edge into rdata_r and slverr_r; PRDATA_O does not use them.
	always_ff @(posedge REF_CLK_I) begin
		rdata_r <= rdata_nxt;
		slverr_r <= slverr_nxt;
	end

	// The slave answers at once; data is presented combinationally from the current image.
	always_comb begin
		PREADY_O = 1'b1;
		PSLVERR_O = access && !mapped;
		PRDATA_O = desc_attr_pkg::ZERO_WORD;
		if (rd_en) begin
			unique case (1'b1)
				hit_a: PRDATA_O = set_a_r;
				hit_b: PRDATA_O = word_b;
				hit_f: PRDATA_O = word_f;
				hit_s: PRDATA_O = word_s;
				default: PRDATA_O = desc_attr_pkg::ZERO_WORD;
			endcase
		end
	end

	// Outputs toward the descriptor engine are forced to zero when emulation is not active.
	// Gating here, rather than in the engine, means that values staged by software while an
	// EEPROM is fitted can never reach descriptor processing by accident.
	always_comb begin
		EMULATION_ACTIVE_O = active_r;
		// Inactive: the engine sees zero lengths and cleared flags.
		CONFIGURATION_STRING_LENGTH_O = '0;
		SERIAL_STRING_LENGTH_O = '0;
		PRODUCT_STRING_LENGTH_O = '0;
		MAKER_STRING_LENGTH_O = '0;
		INTERFACE_STRING_LENGTH_O = '0;
		REMOTE_WAKE_SUPPORT_O = 1'b0;
		POWER_SOURCE_METHOD_O = 1'b0;
		GPIO_WAKE_EVENT_FLAGS_O = '0;
		// Active: the stored fields pass through unchanged.
		if (active_r) begin
			CONFIGURATION_STRING_LENGTH_O = len_field(set_a_r, desc_attr_pkg::CFG_LSB);
			SERIAL_STRING_LENGTH_O = len_field(set_a_r, desc_attr_pkg::SER_LSB);
			PRODUCT_STRING_LENGTH_O = len_field(set_a_r, desc_attr_pkg::PROD_LSB);
			MAKER_STRING_LENGTH_O = len_field(set_a_r, desc_attr_pkg::MAKER_LSB);
			INTERFACE_STRING_LENGTH_O = interface_len_r;
			REMOTE_WAKE_SUPPORT_O = remote_wake_r;
			POWER_SOURCE_METHOD_O = power_method_r;
			GPIO_WAKE_EVENT_FLAGS_O = gpio_flags_r;
		end
	end

	// The registered answer copies are kept only for future wait-state use.
	logic unused_answer;
	assign unused_answer = ^{rdata_r, slverr_r, PROTECTED_RST_I};
endmodule
`default_nettype wire

// file: desc_attr_checker_properties.sv
// Checker of timing relations at the ports of the attribute register block.
`timescale 1ns/10ps
`default_nettype none
module desc_attr_checker (
	input wire logic REF_CLK_I,
	input wire logic SRST_I,
	input wire logic PROTECTED_RST_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [31:0] PADDR_I,
	input wire logic [31:0] PRDATA_O,
	input wire logic PREADY_O,
	input wire logic PSLVERR_O,
	input wire logic EEPROM_PRESENT_I,
	input wire logic EMULATION_ACTIVE_O,
	input wire logic [7:0] CONFIGURATION_STRING_LENGTH_O,
	input wire logic [7:0] INTERFACE_STRING_LENGTH_O,
	input wire logic REMOTE_WAKE_SUPPORT_O,
	input wire logic [7:0] GPIO_WAKE_EVENT_FLAGS_O
);
	// Access phase and decoded hits on the full address.
	wire logic acc = PSEL_I && PENABLE_I;
	wire logic rd = acc && !PWRITE_I;
	wire logic hit_b = PADDR_I == 32'h000000AC;
	wire logic hit_f = PADDR_I == 32'h000000B0;
	wire logic mapped = hit_b || hit_f || PADDR_I == 32'h000000A8 || PADDR_I == 32'h000000B4;
	// Part of the engine view, enough to see a stray update.
	wire logic [23:0] eng = {CONFIGURATION_STRING_LENGTH_O, INTERFACE_STRING_LENGTH_O,
		GPIO_WAKE_EVENT_FLAGS_O};
	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (SRST_I);
	a_ready_zero_wait: assert property (acc |-> PREADY_O)
		else $error("Access phase without ready.");
	a_setb_reserved: assert property (rd && hit_b |-> PRDATA_O[31:8] == 24'h000000)
		else $error("Reserved bits of set B not zero.");
	a_flags_reserved: assert property (
		rd && hit_f |-> PRDATA_O[31:18] == 14'h0000 && PRDATA_O[15:8] == 8'h00)
		else $error("Reserved flag bits not zero.");
	a_unmapped_error: assert property (acc |-> PSLVERR_O == !mapped)
		else $error("Error response does not match the address.");
	a_unmapped_zero: assert property (rd && !mapped |-> PRDATA_O == 32'h00000000)
		else $error("Unmapped read returned data.");
	a_inactive_silent: assert property (
		!EMULATION_ACTIVE_O |-> eng == 24'h000000 && !REMOTE_WAKE_SUPPORT_O)
		else $error("Engine values leak while inactive.");
	a_eeprom_blocks: assert property (EEPROM_PRESENT_I [*4] |=> !EMULATION_ACTIVE_O)
		else $error("Emulation active with memory present.");
	a_protect_keeps: assert property (
		((!PSEL_I) [*3] ##0 (PROTECTED_RST_I && EMULATION_ACTIVE_O)) ##1 EMULATION_ACTIVE_O
		|-> $stable(eng))
		else $error("Protected reset changed contents.");
endmodule
bind descriptor_ram_attribute_regs desc_attr_checker i_chk (.REF_CLK_I(REF_CLK_I), .SRST_I(SRST_I),
	.PROTECTED_RST_I(PROTECTED_RST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
	.PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
	.EEPROM_PRESENT_I(EEPROM_PRESENT_I), .EMULATION_ACTIVE_O(EMULATION_ACTIVE_O),
	.CONFIGURATION_STRING_LENGTH_O(CONFIGURATION_STRING_LENGTH_O),
	.INTERFACE_STRING_LENGTH_O(INTERFACE_STRING_LENGTH_O),
	.REMOTE_WAKE_SUPPORT_O(REMOTE_WAKE_SUPPORT_O), .GPIO_WAKE_EVENT_FLAGS_O(GPIO_WAKE_EVENT_FLAGS_O));
`default_nettype wire

// file: test_descriptor_ram_attribute_regs.sv
// Self-checking bench for the attribute register block.
`timescale 1ns/10ps
`default_nettype none
module test_descriptor_ram_attribute_regs;
	// Register addresses widened to the bus width.
	localparam logic [31:0] RA = 32'(desc_attr_pkg::STRING_LENGTH_SET_A_ADDR);
	localparam logic [31:0] RB = 32'(desc_attr_pkg::STRING_LENGTH_SET_B_ADDR);
	localparam logic [31:0] RF = 32'(desc_attr_pkg::EMULATED_CONFIG_FLAGS_ADDR);
	localparam logic [31:0] RS = 32'(desc_attr_pkg::EMULATION_STATUS_ADDR);
	logic clk = 1'b0, srst = 1'b1, prot = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic [31:0] paddr = 32'h00000000, pwdata = 32'h00000000, prdata, r;
	logic [3:0] pstrb = 4'h0;
	logic pready, pslverr, rws = 1'b0, pms = 1'b0, eep = 1'b0, act, rwo, pmo, e;
	logic [7:0] cfg, ser, prd, mkr, itf, gpio;
	int num_errors = 0, total_checks = 0, cyc = 0;
	descriptor_ram_attribute_regs i_dut (.REF_CLK_I(clk), .SRST_I(srst), .PROTECTED_RST_I(prot),
		.PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
		.PSTRB_I(pstrb), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
		.REMOTE_WAKE_STRAP_I(rws), .POWER_METHOD_STRAP_I(pms), .EEPROM_PRESENT_I(eep),
		.EMULATION_ACTIVE_O(act), .CONFIGURATION_STRING_LENGTH_O(cfg), .SERIAL_STRING_LENGTH_O(ser),
		.PRODUCT_STRING_LENGTH_O(prd), .MAKER_STRING_LENGTH_O(mkr), .INTERFACE_STRING_LENGTH_O(itf),
		.REMOTE_WAKE_SUPPORT_O(rwo), .POWER_SOURCE_METHOD_O(pmo), .GPIO_WAKE_EVENT_FLAGS_O(gpio));
	// Free-running core clock.
	always #20 clk = ~clk;
	// Prints the counts and the verdict, then stops the run.
	task end_of_test;
		$display("Checks %0d, mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// Watchdog; the whole run needs about a hundred cycles.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			num_errors++;
			end_of_test;
		end
	end
	// Compares one value and reports a difference.
	task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
		total_checks++;
		if (s !== x) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, x, s);
		end
	endtask
	// One bus transfer; the wait for ready is bounded only by the watchdog.
	task apb(input logic w, input logic [31:0] a, d, input logic [3:0] s);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	// Reads a register and compares the word.
	task rdc(input logic [31:0] a, x);
		apb(1'b0, a, 32'h00000000, 4'h0);
		chk("rdata", r, x);
		chk("slverr", 32'(e), 32'h00000000);
	endtask
	// Strap levels become the reset values of the two flag bits.
	task t_straps;
		for (int i = 0; i < 2; i++) begin
			rws <= i[0];
			pms <= !i[0];
			srst <= 1'b1;
			repeat (5) @(posedge clk);
			srst <= 1'b0;
			repeat (4) @(posedge clk);
			rdc(RF, {14'h0000, i[0], !i[0], 16'h0000});
			rdc(RA, 32'h00000000);
			rdc(RB, 32'h00000000);
		end
		$display("t_straps done");
	endtask
	// Writable fields, byte lanes and reserved bits.
	task t_fields;
		apb(1'b1, RA, 32'hFFFFFFFF, 4'hF);
		rdc(RA, 32'hFFFFFFFF);
		apb(1'b1, RA, 32'h00000000, 4'h2);
		rdc(RA, 32'hFFFF00FF);
		apb(1'b1, RB, 32'hFFFFFFFF, 4'hF);
		rdc(RB, 32'h000000FF);
		apb(1'b1, RF, 32'hFFFFFFFF, 4'hF);
		rdc(RF, 32'h000300FF);
		apb(1'b0, 32'h000000C0, 32'h00000000, 4'h0);
		chk("slverr", 32'(e), 32'h00000001);
		chk("rdata", r, 32'h00000000);
		apb(1'b1, 32'h000001A8, 32'h00000000, 4'hF);
		rdc(RA, 32'hFFFF00FF);
		$display("t_fields done");
	endtask
	// Values reach the engine only while emulating without memory.
	task t_emulate;
		apb(1'b1, RA, 32'h11223344, 4'hF);
		apb(1'b1, RB, 32'h00000000, 4'hF);
		apb(1'b1, RF, 32'h000200A5, 4'hF);
		apb(1'b1, RS, 32'h00000001, 4'hF);
		repeat (4) @(posedge clk);
		chk("lengths", {cfg, ser, prd, mkr}, 32'h11223344);
		chk("flags", {14'h0000, rwo, pmo, itf, gpio}, 32'h000200A5);
		rdc(RS, 32'h00000005);
		prot <= 1'b1;
		repeat (4) @(posedge clk);
		prot <= 1'b0;
		@(posedge clk);
		chk("lengths", {cfg, ser, prd, mkr}, 32'h11223344);
		eep <= 1'b1;
		repeat (5) @(posedge clk);
		chk("active", {23'h000000, act, gpio}, 32'h00000000);
		rdc(RS, 32'h00000003);
		eep <= 1'b0;
		repeat (5) @(posedge clk);
		chk("lengths", {cfg, ser, prd, mkr}, 32'h11223344);
		$display("t_emulate done");
	endtask
	// Main sequence.
	initial begin
		t_straps;
		t_fields;
		t_emulate;
		end_of_test;
	end
endmodule
`default_nettype wire
